// ===== bench/fepcs_mac_model.sv
/*
 Behavioural RMII MAC for the PCS bench: sends nibbles as dibits, gathers receive nibbles.
 Assumes the bench owns the clock and calls send and clear hierarchically.
*/
`timescale 1ns/1ns
module fepcs_mac_model (
	input wire logic clk_in,
	input wire logic crs_dv_in,
	input wire logic [1:0] rxd_in,
	output logic tx_en_out,
	output logic [1:0] txd_out,
	output logic tx_err_out
);
	logic [3:0] rx_nib [0:31];
	int rx_cnt;
	logic on_q;
	logic hi_q;
	logic prev_q;
	logic [1:0] lo_q;

	// Idle levels at time zero.
	initial begin
		tx_en_out = 1'b0;
		txd_out = 2'h0;
		tx_err_out = 1'b0;
		rx_cnt = 0;
		on_q = 1'b0;
		hi_q = 1'b0;
		prev_q = 1'b0;
	end

	// Forgets what was gathered so the next frame starts clean.
	task automatic clear();
		on_q = 1'b0;
		hi_q = 1'b0;
		rx_cnt = 0;
	endtask

	// Sends len nibbles low dibit first; err marks one nibble's second dibit.
	task automatic send(input logic [63:0] nib, input int len, input int err);
		for (int i = 0; i < len; i++) begin
			@(posedge clk_in);
			tx_en_out <= 1'b1;
			txd_out <= nib[4*i +: 2];
			tx_err_out <= 1'b0;
			@(posedge clk_in);
			txd_out <= nib[4*i+2 +: 2];
			tx_err_out <= (i == err);
		end
		@(posedge clk_in);
		tx_en_out <= 1'b0;
		tx_err_out <= 1'b0;
		txd_out <= ~txd_out;
	endtask

	// Gathers dibits from the first non-zero one while carrier or its toggle phase holds.
	always @(posedge clk_in) begin
		prev_q <= crs_dv_in;
		if ((crs_dv_in || prev_q) && (on_q || rxd_in != 2'h0) && rx_cnt < 32) begin
			on_q <= 1'b1;
			hi_q <= !hi_q;
			lo_q <= rxd_in;
			if (hi_q) begin
				rx_nib[rx_cnt] <= {rxd_in, lo_q};
				rx_cnt <= rx_cnt + 1;
			end
		end
	end
endmodule

// ===== bench/tb_fast_ethernet_pcs_rmii.sv
/*
 Self-checking bench for the PCS: line side driven here, MAC side by the partner model.
 Assumes shortened link timers and APB answers within a few cycles.
*/
`timescale 1ns/1ns
module tb_fast_ethernet_pcs_rmii;
	logic clk = 1'b0;
	logic rst_n = 1'b0;
	logic tx_en, tx_err, crs_dv, rx_er, rx_v = 1'b0, feed = 1'b0, ph = 1'b0;
	logic [1:0] txd, rxd;
	logic [4:0] tx_code, rx_c = 5'h1F;
	logic [4:0] rq [0:31];
	logic [4:0] cap [0:15];
	logic tx_v, flp, scr, nrzi, link_up, link_fail, anr;
	logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0, pready, pslverr;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0, prdata, rd;
	logic crs_q = 1'b0, er_seen = 1'b0, fail_seen = 1'b0, anr_seen = 1'b0, perr;
	logic [1:0] first_rxd = 2'h3;
	logic [39:0] got;
	int rq_rd = 0, rq_wr = 0, nc = 0, err_count = 0, n_compared = 0;

	fepcs_core #(.LINK_UP_CYC(200), .LOCK_WIN_CYC(100)) fepcs_core_inst (
		.ref_clk_in(clk), .rst_n_in(rst_n), .tx_en_in(tx_en), .txd_in(txd),
		.tx_err_in(tx_err), .tx_code_out(tx_code), .tx_code_valid_out(tx_v),
		.tx_flp_out(flp), .scramble_en_out(scr), .nrzi_en_out(nrzi),
		.rx_code_in(rx_c), .rx_code_valid_in(rx_v), .rx_dribble_in(3'h0),
		.crs_dv_out(crs_dv), .rxd_out(rxd), .rx_er_out(rx_er), .link_up_out(link_up),
		.link_fail_out(link_fail), .an_restart_out(anr), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
		.pready(pready), .pslverr(pslverr));

	fepcs_mac_model fepcs_mac_model_inst (.clk_in(clk), .crs_dv_in(crs_dv),
		.rxd_in(rxd), .tx_en_out(tx_en), .txd_out(txd), .tx_err_out(tx_err));

	// Clock at 25 MHz.
	always #20 clk = ~clk;

	// Line side: one group every second cycle, queued groups first, else idle fill.
	always @(posedge clk) begin
		ph <= !ph;
		rx_v <= 1'b0;
		if (!ph && rq_rd != rq_wr) begin
			rx_c <= rq[rq_rd];
			rx_v <= 1'b1;
			rq_rd <= rq_rd + 1;
		end else if (!ph && feed) begin
			rx_c <= 5'h1F;
			rx_v <= 1'b1;
		end
	end

	// Records non-idle transmit groups and sticky event flags.
	always @(posedge clk) begin
		crs_q <= crs_dv;
		if (tx_v && tx_code !== 5'h1F && nc < 16) begin
			cap[nc] <= tx_code;
			nc <= nc + 1;
		end
		if (crs_dv && !crs_q) first_rxd <= rxd;
		if (rx_er) er_seen <= 1'b1;
		if (link_fail) fail_seen <= 1'b1;
		if (anr) anr_seen <= 1'b1;
	end

	task automatic wrap_up();
		$display("compared %0d mismatches %0d", n_compared, err_count);
		if (err_count == 0 && n_compared > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask

	task automatic chk(input logic [39:0] s, input logic [39:0] e);
		n_compared++;
		if (s !== e) begin
			err_count++;
			$display("ERROR %0t: saw %0h expected %0h", $time, s, e);
		end
	endtask

	task automatic cyc(input int n);
		repeat (n) @(posedge clk);
	endtask

	// One APB transfer; the request holds until pready is sampled high.
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int k;
		k = 0;
		@(posedge clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge clk);
		penable <= 1'b1;
		do begin
			@(posedge clk);
			k++;
		end while (pready !== 1'b1 && k < 20);
		rd = prdata;
		perr = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (pready !== 1'b1) begin
			err_count++;
			$display("ERROR %0t: no pready", $time);
			wrap_up();
		end
	endtask

	function automatic logic sig(input int w);
		case (w)
			0: return link_up;
			default: return rxd == 2'h2;
		endcase
	endfunction

	task automatic wait_sig(input int w, input logic v, input int lim);
		int k;
		k = 0;
		while (sig(w) !== v && k < lim) begin
			@(posedge clk);
			k++;
		end
		if (sig(w) !== v) begin
			err_count++;
			$display("ERROR %0t: wait ran out", $time);
			wrap_up();
		end
	endtask

	task automatic rxg(input logic [4:0] c);
		rq[rq_wr] = c;
		rq_wr++;
	endtask

	// Sends one frame and packs the captured groups, first group lowest.
	task automatic tx_frame(input logic [63:0] nib, input int len, input int err);
		nc = 0;
		fepcs_mac_model_inst.send(nib, len, err);
		cyc(12);
		got = '0;
		for (int i = 0; i < nc; i++) got[5*i +: 5] = cap[i];
	endtask

	task automatic t_reset();
		chk(tx_code, 5'h1F);
		apb(1'b0, 8'h00, 32'h0);
		chk(rd, 32'h05);
		apb(1'b0, 8'h04, 32'h0);
		chk(rd, 32'h0);
		apb(1'b1, 8'h08, 32'hFF);
		chk({perr, rd}, {1'b1, 32'h0});
		$display("test reset done");
	endtask

	task automatic t_link();
		feed <= 1'b1;
		cyc(100);
		chk(link_up, 1'b0);
		wait_sig(0, 1'b1, 500);
		apb(1'b0, 8'h04, 32'h0);
		chk({rd[3], rd[0]}, 2'h3);
		$display("test link done");
	endtask

	task automatic t_tx();
		tx_frame(64'hF1055, 5, 99);
		chk(nc, 7);
		chk(got, {5'h07, 5'h0D, 5'h1D, 5'h09, 5'h1E, 5'h11, 5'h18});
		chk(tx_code, 5'h1F);
		tx_frame(64'h3A55, 4, 3);
		chk(got, {5'h07, 5'h0D, 5'h04, 5'h16, 5'h11, 5'h18});
		$display("test transmit done");
	endtask

	task automatic t_rx();
		fepcs_mac_model_inst.clear();
		rxg(5'h18); rxg(5'h11); rxg(5'h1E); rxg(5'h09);
		rxg(5'h1D); rxg(5'h16); rxg(5'h0D); rxg(5'h07);
		cyc(50);
		chk(first_rxd, 2'h0);
		chk(fepcs_mac_model_inst.rx_cnt >= 6, 1'b1);
		got = '0;
		for (int i = 0; i < 6; i++) got[4*i +: 4] = fepcs_mac_model_inst.rx_nib[i];
		chk(got, 24'hAF1055);
		chk(crs_dv, 1'b0);
		// Carrier drops on idle while nibbles still wait; all of them must still arrive.
		fepcs_mac_model_inst.clear();
		rxg(5'h18); rxg(5'h11); rxg(5'h1E); rxg(5'h09);
		cyc(40);
		chk(fepcs_mac_model_inst.rx_cnt >= 4, 1'b1);
		got = '0;
		for (int i = 0; i < 4; i++) got[4*i +: 4] = fepcs_mac_model_inst.rx_nib[i];
		chk(got, 16'h1055);
		er_seen = 1'b0;
		rxg(5'h18); rxg(5'h11); rxg(5'h1E); rxg(5'h19);
		rxg(5'h00); rxg(5'h0D); rxg(5'h07);
		cyc(40);
		chk(er_seen, 1'b1);
		rxg(5'h18); rxg(5'h1E); rxg(5'h1E);
		wait_sig(1, 1'b1, 30);
		cyc(30);
		$display("test receive done");
	endtask

	task automatic t_loss();
		feed <= 1'b0;
		fail_seen = 1'b0;
		anr_seen = 1'b0;
		wait_sig(0, 1'b0, 500);
		cyc(3);
		chk({fail_seen, anr_seen, flp}, 3'h7);
		apb(1'b0, 8'h04, 32'h0);
		chk(rd[1:0], 2'h2);
		apb(1'b1, 8'h04, 32'h2);
		apb(1'b0, 8'h04, 32'h0);
		chk(rd[1], 1'b0);
		tx_frame(64'h055, 3, 99);
		chk(nc, 0);
		apb(1'b1, 8'h00, 32'h09);
		cyc(3);
		chk(flp, 1'b0);
		tx_frame(64'h055, 3, 99);
		chk(got[9:0], {5'h11, 5'h18});
		apb(1'b1, 8'h00, 32'h0D);
		cyc(3);
		chk(flp, 1'b1);
		$display("test link loss done");
	endtask

	task automatic t_modes();
		logic [7:0] cv [3];
		logic [1:0] ev [3];
		cv = '{8'h01, 8'h03, 8'h11};
		ev = '{2'h2, 2'h1, 2'h0};
		for (int i = 0; i < 3; i++) begin
			apb(1'b1, 8'h00, {24'h0, cv[i]});
			cyc(3);
			chk({scr, nrzi}, ev[i]);
		end
		// Ten megabit mode: raw nibbles go out with no delimiters.
		apb(1'b1, 8'h00, 32'h0);
		cyc(3);
		tx_frame(64'h3A, 2, 99);
		chk(nc, 2);
		chk(got[9:0], {5'h03, 5'h0A});
		$display("test modes done");
	endtask

	// Main sequence.
	initial begin
		cyc(8);
		rst_n <= 1'b1;
		cyc(1);
		t_reset();
		t_link();
		t_tx();
		t_rx();
		t_loss();
		t_modes();
		wrap_up();
	end
endmodule

// ===== rtl/fepcs_core.sv
/*
 100BASE-X PCS for one RMII port: 4B/5B transmit and receive, delimiters, link monitor,
 CRS_DV generation and an APB register slave. Assumes the MAC and line side logic run on
 ref_clk_in, one dibit per clock, and the line side offers one code group per two clocks.
*/
// Chosen here: the APB interface to the registers and the placing of the registers.
`timescale 1ns/1ns
module fepcs_core #(
	parameter int LINK_UP_CYC = fepcs_pkg::LINK_UP_CYC,
	parameter int LOCK_WIN_CYC = fepcs_pkg::LOCK_WIN_CYC,
	parameter int FIFO_DEPTH = 4
) (
	input wire logic ref_clk_in,
	input wire logic rst_n_in,
	input wire logic tx_en_in,
	input wire logic [1:0] txd_in,
	input wire logic tx_err_in,
	output logic [4:0] tx_code_out,
	output logic tx_code_valid_out,
	output logic tx_flp_out,
	output logic scramble_en_out,
	output logic nrzi_en_out,
	input wire logic [4:0] rx_code_in,
	input wire logic rx_code_valid_in,
	input wire logic [2:0] rx_dribble_in,
	output logic crs_dv_out,
	output logic [1:0] rxd_out,
	output logic rx_er_out,
	output logic link_up_out,
	output logic link_fail_out,
	output logic an_restart_out,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr
);
	typedef enum logic [1:0] {TS_IDLE, TS_DATA, TS_T, TS_R} fepcs_tx_t;
	typedef enum logic [2:0] {RS_IDLE, RS_K, RS_DATA, RS_R, RS_FALSE} fepcs_rx_t;
	localparam int AW = $clog2(FIFO_DEPTH);
	localparam int LW = $clog2(LINK_UP_CYC + 1);
	localparam int WW = $clog2(LOCK_WIN_CYC + 1);

	logic [4:0] ctrl_q;
	logic fail_q;
	logic speed100, an_en, tx_ok;
	fepcs_tx_t tx_st_q;
	logic tx_ph_q;
	logic [1:0] tx_lo_q;
	logic tx_first_q, tx_second_q;
	fepcs_rx_t rx_st_q;
	logic [3:0] fifo_q [FIFO_DEPTH];
	logic [AW-1:0] wr_q, rd_q;
	logic [AW:0] cnt_q;
	logic [AW:0] cnt_d;
	logic [1:0] push_n;
	logic [3:0] push_a, push_b;
	logic pop, out_ph_q, carrier_q, tog_q;
	logic [3:0] tog_cnt_q;
	logic [3:0] run_q;
	logic seen_q, lock_q, run_done;
	logic [LW-1:0] lock_cnt_q;
	logic [WW-1:0] win_q;
	logic link_up_q;

	assign speed100 = ctrl_q[fepcs_pkg::CTL_SPEED100];
	assign an_en = ctrl_q[fepcs_pkg::CTL_AN_EN];
	// Data may go out with link, or forced while negotiation is off.
	assign tx_ok = link_up_q || (ctrl_q[fepcs_pkg::CTL_FORCE] && !an_en);

	// APB slave: no wait states, answer registered in the setup phase.
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			ctrl_q <= fepcs_pkg::CTL_RESET;
			pready <= 1'b0;
			prdata <= 32'h00000000;
			pslverr <= 1'b0;
		end else begin
			pready <= psel && !penable;
			pslverr <= 1'b0;
			prdata <= 32'h00000000;
			if (psel && !penable) begin
				if (paddr == fepcs_pkg::OFF_CTRL) begin
					prdata <= {27'h0000000, ctrl_q};
				end else if (paddr == fepcs_pkg::OFF_STAT) begin
					prdata <= {28'h0000000, lock_q, carrier_q, fail_q, link_up_q};
				end else begin
					pslverr <= 1'b1;
				end
			end
			if (psel && penable && pready && pwrite && paddr == fepcs_pkg::OFF_CTRL) begin
				ctrl_q <= pwdata[4:0];
			end
		end
	end

	// Sticky link failure; a new failure wins over the write-one clear.
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			fail_q <= 1'b0;
		end else if (link_up_q && !lock_q) begin
			fail_q <= 1'b1;
		end else if (psel && penable && pready && pwrite && paddr == fepcs_pkg::OFF_STAT
			&& pwdata[fepcs_pkg::ST_FAIL]) begin
			fail_q <= 1'b0;
		end
	end

	// Line mode selects follow the control register.
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			scramble_en_out <= 1'b0;
			nrzi_en_out <= 1'b0;
		end else begin
			scramble_en_out <= speed100 && !ctrl_q[fepcs_pkg::CTL_FIBER]
				&& !ctrl_q[fepcs_pkg::CTL_SCR_BYP];
			nrzi_en_out <= speed100 && ctrl_q[fepcs_pkg::CTL_FIBER];
		end
	end

	// Transmit: dibits pair low first into nibbles, one code group every two clocks.
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			tx_st_q <= TS_IDLE;
			tx_ph_q <= 1'b0;
			tx_lo_q <= 2'h0;
			tx_first_q <= 1'b0;
			tx_second_q <= 1'b0;
			tx_code_out <= fepcs_pkg::CG_IDLE;
			tx_code_valid_out <= 1'b0;
			tx_flp_out <= 1'b0;
		end else begin
			tx_code_valid_out <= 1'b0;
			tx_flp_out <= !tx_ok && speed100;
			tx_ph_q <= !tx_ph_q;
			case (tx_st_q)
				TS_IDLE: begin
					if (tx_en_in && (tx_ok || !speed100)) begin
						tx_st_q <= TS_DATA;
						tx_lo_q <= txd_in;
						tx_ph_q <= 1'b1;
						tx_first_q <= 1'b1;
						tx_second_q <= 1'b0;
					end else if (tx_ph_q && tx_ok && speed100) begin
						tx_code_out <= fepcs_pkg::CG_IDLE;
						tx_code_valid_out <= 1'b1;
					end
				end
				TS_DATA: begin
					if (!tx_ph_q) begin
						tx_lo_q <= txd_in;
						if (!tx_en_in) begin
							tx_st_q <= speed100 ? TS_T : TS_IDLE;
							tx_ph_q <= 1'b1;
						end
					end else begin
						tx_code_valid_out <= 1'b1;
						tx_first_q <= 1'b0;
						tx_second_q <= tx_first_q;
						if (!speed100) begin
							tx_code_out <= {1'b0, txd_in, tx_lo_q};
						end else if (tx_first_q) begin
							tx_code_out <= fepcs_pkg::CG_J;
						end else if (tx_second_q) begin
							tx_code_out <= fepcs_pkg::CG_K;
						end else if (tx_err_in) begin
							tx_code_out <= fepcs_pkg::CG_H;
						end else begin
							tx_code_out <= fepcs_pkg::enc({txd_in, tx_lo_q});
						end
						if (!tx_en_in) begin
							tx_st_q <= speed100 ? TS_T : TS_IDLE;
						end
					end
				end
				TS_T: begin
					if (tx_ph_q) begin
						tx_code_out <= fepcs_pkg::CG_T;
						tx_code_valid_out <= 1'b1;
						tx_st_q <= TS_R;
					end
				end
				TS_R: begin
					if (tx_ph_q) begin
						tx_code_out <= fepcs_pkg::CG_R;
						tx_code_valid_out <= 1'b1;
						tx_st_q <= TS_IDLE;
					end
				end
				default: tx_st_q <= TS_IDLE;
			endcase
		end
	end

	// Receive decoder: delimiter checks and nibble pushes into the drain buffer.
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			rx_st_q <= RS_IDLE;
			carrier_q <= 1'b0;
		end else if (rx_code_valid_in && !speed100) begin
			carrier_q <= rx_code_in[4];
			rx_st_q <= rx_code_in[4] ? RS_DATA : RS_IDLE;
		end else if (rx_code_valid_in) begin
			carrier_q <= rx_code_in != fepcs_pkg::CG_IDLE;
			case (rx_st_q)
				RS_IDLE: begin
					if (rx_code_in == fepcs_pkg::CG_J) begin
						rx_st_q <= RS_K;
					end else if (rx_code_in != fepcs_pkg::CG_IDLE) begin
						rx_st_q <= RS_FALSE;
					end
				end
				RS_K: rx_st_q <= (rx_code_in == fepcs_pkg::CG_K) ? RS_DATA : RS_FALSE;
				RS_DATA: begin
					if (rx_code_in == fepcs_pkg::CG_T) begin
						rx_st_q <= RS_R;
					end else if (rx_code_in == fepcs_pkg::CG_IDLE) begin
						rx_st_q <= RS_IDLE;
					end
				end
				RS_R: rx_st_q <= (rx_code_in == fepcs_pkg::CG_R) ? RS_IDLE : RS_FALSE;
				RS_FALSE: begin
					if (rx_code_in == fepcs_pkg::CG_IDLE) begin
						rx_st_q <= RS_IDLE;
					end
				end
				default: rx_st_q <= RS_IDLE;
			endcase
		end
	end

	// Nibbles to push for the current code group.
	always_comb begin
		push_n = 2'd0;
		push_a = rx_code_in[3:0];
		push_b = fepcs_pkg::NIB_PRE;
		if (rx_code_valid_in && !speed100) begin
			if (rx_code_in[4]) begin
				push_n = 2'd1;
			end else if (rx_st_q == RS_DATA && rx_dribble_in != 3'h0 && rx_dribble_in < 3'h5) begin
				push_n = 2'd1;
				push_a = rx_code_in[3:0] | (4'hF << rx_dribble_in);
			end
		end else if (rx_code_valid_in) begin
			if (rx_st_q == RS_K && rx_code_in == fepcs_pkg::CG_K) begin
				push_n = 2'd2;
				push_a = fepcs_pkg::NIB_PRE;
			end else if (rx_st_q == RS_DATA && rx_code_in != fepcs_pkg::CG_T
				&& rx_code_in != fepcs_pkg::CG_IDLE) begin
				push_n = 2'd1;
				push_a = fepcs_pkg::dec(rx_code_in);
			end
		end
	end

	// Drain buffer: pop one nibble per two clocks, low dibit first.
	assign pop = out_ph_q && cnt_q != '0;
	assign cnt_d = cnt_q + (AW+1)'(push_n) - (AW+1)'(pop);
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			wr_q <= '0;
			rd_q <= '0;
			cnt_q <= '0;
			out_ph_q <= 1'b0;
		end else begin
			out_ph_q <= (cnt_q != '0) ? !out_ph_q : 1'b0;
			if (pop) begin
				rd_q <= rd_q + AW'(1);
			end
			if (push_n != 2'd0) begin
				fifo_q[wr_q] <= push_a;
				if (push_n == 2'd2) begin
					fifo_q[wr_q + AW'(1)] <= push_b;
				end
				wr_q <= wr_q + AW'(push_n);
			end
			cnt_q <= cnt_d;
		end
	end

	// RMII receive outputs; carrier valid toggles while the buffer drains.
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			crs_dv_out <= 1'b0;
			rxd_out <= 2'h0;
			rx_er_out <= 1'b0;
			tog_q <= 1'b1;
			tog_cnt_q <= 4'h0;
		end else begin
			tog_cnt_q <= (speed100 || tog_cnt_q == 4'(fepcs_pkg::TOG10_CYC - 1)) ? 4'h0
				: tog_cnt_q + 4'h1;
			if (carrier_q || cnt_q == '0) begin
				tog_q <= 1'b1;
			end else if (tog_cnt_q == 4'h0) begin
				tog_q <= !tog_q;
			end
			crs_dv_out <= carrier_q || (cnt_q != '0 && tog_q);
			if (rx_st_q == RS_FALSE) begin
				rxd_out <= fepcs_pkg::JAM_FALSE;
			end else if (cnt_q == '0) begin
				rxd_out <= 2'h0;
			end else begin
				rxd_out <= out_ph_q ? fifo_q[rd_q][3:2] : fifo_q[rd_q][1:0];
			end
			rx_er_out <= rx_code_valid_in && speed100 && (rx_st_q == RS_DATA || rx_st_q == RS_R)
				&& fepcs_pkg::CG_INVALID[rx_code_in];
		end
	end

	// A run of twelve idles in a row completes here; the count then restarts.
	assign run_done = rx_code_valid_in && rx_code_in == fepcs_pkg::CG_IDLE
		&& run_q == 4'(fepcs_pkg::IDLE_RUN - 1);

	// Lock monitor: a completed run locks; a window with no fresh run, or a silent line, unlocks.
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in || !speed100) begin
			run_q <= 4'h0;
			seen_q <= 1'b0;
			lock_q <= 1'b0;
			win_q <= '0;
		end else begin
			win_q <= (win_q == WW'(LOCK_WIN_CYC - 1)) ? '0 : win_q + WW'(1);
			if (rx_code_valid_in) begin
				run_q <= (rx_code_in != fepcs_pkg::CG_IDLE || run_done) ? 4'h0 : run_q + 4'h1;
			end
			if (run_done) begin
				lock_q <= 1'b1;
			end
			if (win_q == WW'(LOCK_WIN_CYC - 1)) begin
				seen_q <= 1'b0;
				if (!seen_q && !run_done) begin
					lock_q <= 1'b0;
				end
			end else if (run_done) begin
				seen_q <= 1'b1;
			end
		end
	end

	// Link timer; only the fast path raises link, so slow link never follows idles.
	always_ff @(posedge ref_clk_in) begin
		if (!rst_n_in) begin
			lock_cnt_q <= '0;
			link_up_q <= 1'b0;
			link_up_out <= 1'b0;
			link_fail_out <= 1'b0;
			an_restart_out <= 1'b0;
		end else begin
			link_fail_out <= link_up_q && !lock_q;
			an_restart_out <= link_up_q && !lock_q && an_en;
			link_up_out <= link_up_q && lock_q;
			if (!lock_q || !speed100) begin
				lock_cnt_q <= '0;
				link_up_q <= 1'b0;
			end else if (lock_cnt_q == LW'(LINK_UP_CYC - 1)) begin
				link_up_q <= 1'b1;
			end else begin
				lock_cnt_q <= lock_cnt_q + LW'(1);
			end
		end
	end

	// Checks.
	property p_idle_fill;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		(tx_st_q == TS_IDLE && tx_code_valid_out && !$past(tx_st_q == TS_R)) |-> tx_code_out == fepcs_pkg::CG_IDLE;
	endproperty
	a_idle_fill: assert property (p_idle_fill) else $error("non idle group between frames");
	property p_jk;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		(speed100 && tx_code_valid_out && tx_code_out == fepcs_pkg::CG_J && tx_second_q)
		|-> ##2 (tx_code_valid_out && (tx_code_out == fepcs_pkg::CG_K || tx_code_out == fepcs_pkg::CG_T));
	endproperty
	a_jk: assert property (p_jk) else $error("J not followed by K");
	property p_tr;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		(tx_code_valid_out && tx_code_out == fepcs_pkg::CG_T && tx_st_q == TS_R)
		|-> ##2 (tx_code_valid_out && tx_code_out == fepcs_pkg::CG_R);
	endproperty
	a_tr: assert property (p_tr) else $error("T not followed by R");
	property p_pre;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		(speed100 && rx_code_valid_in && rx_st_q == RS_K && rx_code_in == fepcs_pkg::CG_K && !pop)
		|=> cnt_q == $past(cnt_q) + 2;
	endproperty
	a_pre: assert property (p_pre) else $error("two preamble nibbles not queued");
	property p_link_up;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		$rose(link_up_q) |-> $past(lock_q) && lock_cnt_q == LW'(LINK_UP_CYC - 1);
	endproperty
	a_link_up: assert property (p_link_up) else $error("link up without full lock time");
	property p_restart;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		$fell(link_up_q) && an_en && speed100 |-> an_restart_out && link_fail_out;
	endproperty
	a_restart: assert property (p_restart) else $error("no restart on link loss");
	property p_flp;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		(speed100 && !tx_ok) |=> tx_flp_out;
	endproperty
	a_flp: assert property (p_flp) else $error("no bursts while link down");
	property p_crs;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		(speed100 && rx_code_valid_in && rx_code_in != fepcs_pkg::CG_IDLE) |=> ##1 crs_dv_out;
	endproperty
	a_crs: assert property (p_crs) else $error("carrier valid missed");
	property p_inv;
		@(posedge ref_clk_in) disable iff (!rst_n_in)
		(speed100 && rx_code_valid_in && rx_st_q == RS_DATA && rx_code_in == 5'h00) |=> rx_er_out;
	endproperty
	a_inv: assert property (p_inv) else $error("invalid group not flagged");
	c_jk: cover property (@(posedge ref_clk_in) tx_code_valid_out && tx_code_out == fepcs_pkg::CG_K);
	c_link: cover property (@(posedge ref_clk_in) $rose(link_up_q));
	c_drain: cover property (@(posedge ref_clk_in) !carrier_q && cnt_q != '0 && $fell(crs_dv_out));
	c_false: cover property (@(posedge ref_clk_in) rx_st_q == RS_FALSE);
endmodule

// ===== rtl/fepcs_pkg.sv
/*
 Constants, code groups, register map and coder functions for the 100BASE-X PCS block.
 Assumes one 25 MHz clock; every user refers to items by fepcs_pkg::name.
*/
package fepcs_pkg;
	// Five-bit code groups.
	localparam logic [4:0] CG_IDLE = 5'h1F;
	localparam logic [4:0] CG_J = 5'h18;
	localparam logic [4:0] CG_K = 5'h11;
	localparam logic [4:0] CG_T = 5'h0D;
	localparam logic [4:0] CG_R = 5'h07;
	localparam logic [4:0] CG_H = 5'h04;
	// One bit per invalid five-bit group, indexed by the group.
	localparam logic [31:0] CG_INVALID = 32'h0201116F;
	localparam logic [3:0] NIB_PRE = 4'h5;
	localparam logic [1:0] JAM_FALSE = 2'h2;
	// Register byte offsets.
	localparam logic [7:0] OFF_CTRL = 8'h00;
	localparam logic [7:0] OFF_STAT = 8'h04;
	// Control fields.
	localparam int CTL_SPEED100 = 0;
	localparam int CTL_FIBER = 1;
	localparam int CTL_AN_EN = 2;
	localparam int CTL_FORCE = 3;
	localparam int CTL_SCR_BYP = 4;
	localparam logic [4:0] CTL_RESET = 5'h05;
	// Status fields.
	localparam int ST_LINK = 0;
	localparam int ST_FAIL = 1;
	localparam int ST_RXACT = 2;
	localparam int ST_LOCK = 3;
	// Timing.
	localparam int CLK_KHZ = 25000;
	localparam int LINK_UP_MS = 50;
	localparam int LOCK_WIN_MS = 2;
	localparam int LINK_UP_CYC = LINK_UP_MS * CLK_KHZ;
	localparam int LOCK_WIN_CYC = LOCK_WIN_MS * CLK_KHZ;
	localparam int IDLE_RUN = 12;
	localparam int TOG10_CYC = 10;

	// Nibble to data code group.
	function automatic logic [4:0] enc(input logic [3:0] n);
		logic [4:0] t [16];
		t = '{5'h1E, 5'h09, 5'h14, 5'h15, 5'h0A, 5'h0B, 5'h0E, 5'h0F,
			5'h12, 5'h13, 5'h16, 5'h17, 5'h1A, 5'h1B, 5'h1C, 5'h1D};
		return t[n];
	endfunction

	// Data code group back to its nibble; zero for non-data groups.
	function automatic logic [3:0] dec(input logic [4:0] c);
		logic [3:0] r;
		r = 4'h0;
		for (int i = 0; i < 16; i++) begin
			if (enc(4'(i)) == c) begin
				r = 4'(i);
			end
		end
		return r;
	endfunction
endpackage
